// [bench/device_descriptor_table_walker_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module device_descriptor_table_walker_tb;
    // ==================================================================
    // stimulus, outputs, counters
    logic CLOCK_IN = 1'b0;
    logic RESET_N_IN = 1'b0;
    logic REQ_VALID_IN = 1'b0;
    logic [7:0] REQ_TAG_IN = 8'h00;
    logic [7:0] REQ_EXT_TAG_IN = 8'h00;
    logic [3:0] lat = 4'h2;
    logic BUSY_OUT, MEM_RD_OUT, MEM_VALID_IN, DONE_OUT, FOUND_OUT;
    logic LEGACY_OUT, ENTRY_VALID_OUT;
    logic [7:0] MEM_DATA_IN;
    logic [15:0] MEM_ADDR_OUT, DESC_ADDR_OUT, DESC_LEN_OUT;
    logic [15:0] TABLE_BYTES_OUT, STORED_CRC_OUT;
    walker_pkg::tag_class_t TAG_CLASS_OUT;
    walker_pkg::entry_t ENTRY_OUT;
    logic [50:0] got [$];
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    // blank, ext, cal12, discovery, end
    logic [7:0] chain [0:34] = '{8'h05, 8'h03, 8'h00, 8'h00, 8'h00,
        8'hFE, 8'h07, 8'h02, 8'h00, 8'hAA, 8'hBB, 8'h11, 8'h04, 8'h11,
        8'h22, 8'h33, 8'h44, 8'h02, 8'h0F, 8'h30, 8'h0E, 8'h96, 8'h2E,
        8'h00, 8'h03, 8'h02, 8'h10, 8'h51, 8'h8A, 8'hFE, 8'h00, 8'h81,
        8'h51, 8'h00, 8'hFF};
    always #2.5 CLOCK_IN = ~CLOCK_IN;
    descriptor_walker dut (.CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN),
        .REQ_VALID_IN(REQ_VALID_IN), .REQ_TAG_IN(REQ_TAG_IN),
        .REQ_EXT_TAG_IN(REQ_EXT_TAG_IN), .BUSY_OUT(BUSY_OUT),
        .MEM_RD_OUT(MEM_RD_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
        .MEM_VALID_IN(MEM_VALID_IN), .MEM_DATA_IN(MEM_DATA_IN),
        .DONE_OUT(DONE_OUT), .FOUND_OUT(FOUND_OUT), .LEGACY_OUT(LEGACY_OUT),
        .DESC_ADDR_OUT(DESC_ADDR_OUT), .DESC_LEN_OUT(DESC_LEN_OUT),
        .TAG_CLASS_OUT(TAG_CLASS_OUT), .TABLE_BYTES_OUT(TABLE_BYTES_OUT),
        .STORED_CRC_OUT(STORED_CRC_OUT), .ENTRY_VALID_OUT(ENTRY_VALID_OUT),
        .ENTRY_OUT(ENTRY_OUT));
    table_mem mem_u (.clk_in(CLOCK_IN), .rd_in(MEM_RD_OUT),
        .addr_in(MEM_ADDR_OUT), .lat_in(lat), .valid_out(MEM_VALID_IN),
        .data_out(MEM_DATA_IN));
    // log entries; stop a hung run
    always @(negedge CLOCK_IN) begin
        if (ENTRY_VALID_OUT === 1'b1) got.push_back(
            ENTRY_OUT.kind == walker_pkg::ENT_MEMORY ?
            {ENTRY_OUT.kind, ENTRY_OUT.address, 2'h0, ENTRY_OUT.mem_type,
            ENTRY_OUT.size_bytes} : {ENTRY_OUT.kind, ENTRY_OUT.address,
            15'h0000, ENTRY_OUT.peripheral_identifier, ENTRY_OUT.id_class});
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [63:0] seen,
        input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one search; request held h extra cycles
    task automatic search(input logic [7:0] t, input logic [7:0] x,
        input int h);
        @(negedge CLOCK_IN);
        REQ_TAG_IN = t;
        REQ_EXT_TAG_IN = x;
        REQ_VALID_IN = 1'b1;
        @(negedge CLOCK_IN);
        REQ_TAG_IN = 8'h05;
        repeat (h) @(negedge CLOCK_IN);
        REQ_VALID_IN = 1'b0;
        while (DONE_OUT !== 1'b1) @(negedge CLOCK_IN);
    endtask : search
    task automatic hit(input logic [15:0] a, input logic [15:0] l,
        input walker_pkg::tag_class_t c);
        check("result", {FOUND_OUT, DESC_ADDR_OUT, DESC_LEN_OUT}, {1'b1, a, l});
        check("class", TAG_CLASS_OUT, c);
    endtask : hit
    task automatic t_legacy;
        mem_u.mem[16'h0FF0] = 8'h12;
        search(8'h11, 8'h00, 0);
        check("legacy", {LEGACY_OUT, FOUND_OUT}, 2'h2);
        check("flat addr", DESC_ADDR_OUT, walker_pkg::LEGACY_ADDR);
        $display("legacy done");
    endtask : t_legacy
    task automatic t_chain;
        mem_u.mem[16'h0FF0] = 8'h80;
        mem_u.mem[16'h1A00] = 8'h06;
        mem_u.mem[16'h1A02] = 8'h34;
        mem_u.mem[16'h1A03] = 8'h12;
        foreach (chain[i]) mem_u.mem[16'h1A08 + 16'(i)] = chain[i];
        search(8'h05, 8'h00, 0);
        hit(16'h1A08, 16'h0003, walker_pkg::CLS_BLANK);
        search(8'hFE, 8'h07, 0);
        hit(16'h1A0D, 16'h0002, walker_pkg::CLS_EXTENDER);
        search(8'h11, 8'h00, 4);
        hit(16'h1A13, 16'h0004, walker_pkg::CLS_CAL12);
        check("table bytes", TABLE_BYTES_OUT, 16'h0100);
        check("stored crc", STORED_CRC_OUT, 16'h1234);
        search(8'h13, 8'h00, 0);
        check("miss", {FOUND_OUT, LEGACY_OUT}, 2'h0);
        $display("chain done");
    endtask : t_chain
    task automatic t_disc;
        logic [50:0] want [0:6] = '{
            {walker_pkg::ENT_MEMORY, 24'h00_1C00, 2'h0, 3'h1, 20'h0_4000},
            {walker_pkg::ENT_MEMORY, 24'h00_5C00, 2'h0, 3'h4, 20'h2_0000},
            {walker_pkg::ENT_PERIPHERAL, 24'h00_0100, 15'h0000, 8'h02,
            walker_pkg::ID_IS_MODULE}, {walker_pkg::ENT_PERIPHERAL,
            24'h00_5100, 15'h0000, 8'h51, walker_pkg::ID_IS_MODULE},
            {walker_pkg::ENT_PERIPHERAL, 24'h00_5100, 15'h0000, 8'hFE,
            walker_pkg::ID_IS_SPECIAL}, {walker_pkg::ENT_INTERRUPT,
            24'h00_FFF8, 15'h0000, 8'h81, walker_pkg::ID_IS_MODULE},
            {walker_pkg::ENT_INTERRUPT, 24'h00_FFF6, 15'h0000, 8'h51,
            walker_pkg::ID_IS_MODULE}};
        lat = 4'h0;
        got.delete();
        search(8'h02, 8'h00, 0);
        hit(16'h1A19, 16'h000F, walker_pkg::CLS_DISCOVERY);
        check("entry count", got.size(), 7);
        foreach (want[i]) check("entry", got[i], want[i]);
        $display("discovery done");
    endtask : t_disc
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (2) @(negedge CLOCK_IN);
        RESET_N_IN = 1'b1;
        t_legacy();
        t_chain();
        t_disc();
        tally_and_finish();
    end
endmodule : device_descriptor_table_walker_tb
bind descriptor_walker walker_checker chk (.CLOCK_IN(CLOCK_IN),
    .RESET_N_IN(RESET_N_IN), .BUSY_OUT(BUSY_OUT), .MEM_RD_OUT(MEM_RD_OUT),
    .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_VALID_IN(MEM_VALID_IN),
    .MEM_DATA_IN(MEM_DATA_IN), .DONE_OUT(DONE_OUT), .FOUND_OUT(FOUND_OUT),
    .LEGACY_OUT(LEGACY_OUT), .DESC_ADDR_OUT(DESC_ADDR_OUT),
    .ENTRY_VALID_OUT(ENTRY_VALID_OUT));
`default_nettype wire

// [bench/table_mem.sv]
`timescale 1ns/100ps
`default_nettype none
module table_mem (
    input wire logic clk_in,
    input wire logic rd_in,
    input wire logic [15:0] addr_in,
    input wire logic [3:0] lat_in,
    output logic valid_out,
    output logic [7:0] data_out
);
    // ==================================================================
    // table contents
    logic [7:0] mem [0:65535];
    logic [7:0] last_r;
    logic [4:0] cnt_r;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        valid_out = 1'b0;
        data_out = 8'h00;
        last_r = 8'h00;
        cnt_r = 5'h00;
    end
    // answer reads lat_in + 1 cycles after the strobe is sampled; junk otherwise
    always @(posedge clk_in) begin
        valid_out <= 1'b0;
        data_out <= ~last_r;
        if (rd_in) cnt_r <= {1'b0, lat_in} + 5'h01;
        else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
        if (!rd_in && cnt_r == 5'h01) begin
            valid_out <= 1'b1;
            data_out <= mem[addr_in];
            last_r <= mem[addr_in];
        end
    end
endmodule : table_mem
`default_nettype wire

// [bench/walker_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module walker_checker (
    input wire logic CLOCK_IN,
    input wire logic RESET_N_IN,
    input wire logic BUSY_OUT,
    input wire logic MEM_RD_OUT,
    input wire logic [15:0] MEM_ADDR_OUT,
    input wire logic MEM_VALID_IN,
    input wire logic [7:0] MEM_DATA_IN,
    input wire logic DONE_OUT,
    input wire logic FOUND_OUT,
    input wire logic LEGACY_OUT,
    input wire logic [15:0] DESC_ADDR_OUT,
    input wire logic ENTRY_VALID_OUT
);
    // ==================================================================
    // read tracking
    logic pend_r;
    logic take;
    logic fam;
    assign take = pend_r && MEM_VALID_IN;
    assign fam = take && MEM_ADDR_OUT == walker_pkg::FAMILY_ADDR;
    // pending from strobe to data
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) pend_r <= 1'b0;
        else pend_r <= MEM_RD_OUT || (pend_r && !MEM_VALID_IN);
    end
    // ==================================================================
    // properties
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESET_N_IN);
    a_rd_pulse: assert property (MEM_RD_OUT |=> !MEM_RD_OUT)
        else $error("read strobe long");
    a_addr_hold: assert property (
        pend_r && !MEM_VALID_IN |=> $stable(MEM_ADDR_OUT))
        else $error("read address moved");
    a_family_first: assert property (
        $rose(BUSY_OUT) |-> ##[1:2]
        (MEM_RD_OUT && MEM_ADDR_OUT == walker_pkg::FAMILY_ADDR))
        else $error("first read not family byte");
    a_hier_info: assert property (
        fam && MEM_DATA_IN == walker_pkg::HIER_MARK |-> ##2
        (MEM_RD_OUT && MEM_ADDR_OUT == walker_pkg::INFO_LEN_ADDR))
        else $error("no info read after marker");
    a_legacy_end: assert property (
        fam && MEM_DATA_IN != walker_pkg::HIER_MARK |-> ##2
        (DONE_OUT && LEGACY_OUT && !FOUND_OUT
        && DESC_ADDR_OUT == walker_pkg::LEGACY_ADDR))
        else $error("flat layout not reported");
    a_chain_start: assert property (
        take && MEM_ADDR_OUT == walker_pkg::CRC_HI_ADDR |-> ##2
        (MEM_RD_OUT && MEM_ADDR_OUT == walker_pkg::CHAIN_START_ADDRESS))
        else $error("chain start wrong");
    a_done_end: assert property (
        DONE_OUT |-> $past(BUSY_OUT) && !BUSY_OUT ##1 !DONE_OUT)
        else $error("done pulse wrong");
    a_entry_busy: assert property (
        ENTRY_VALID_OUT |-> BUSY_OUT && !DONE_OUT)
        else $error("entry outside a search");
endmodule : walker_checker
`default_nettype wire

// [rtl/descriptor_walker.sv]
// What this block does
// - read the family-branch byte first to choose the layout
// - search starts at the fixed chain start address
// - tags up to the extender limit carry a one-byte length
// - extender tag: next byte extends tag, two bytes give length
// - discovery body: memory words, zero, count, words, irq bytes, zero
// - interrupt entries pass on in table priority order
// - stored check value is fetched and passed out unverified
// - stored check value is low byte first, then high byte
`timescale 1ns/100ps
`default_nettype none
module descriptor_walker (
    input wire logic CLOCK_IN,
    input wire logic RESET_N_IN,
    input wire logic REQ_VALID_IN,
    input wire logic [7:0] REQ_TAG_IN,
    input wire logic [7:0] REQ_EXT_TAG_IN,
    output logic BUSY_OUT,
    output logic MEM_RD_OUT,
    output logic [15:0] MEM_ADDR_OUT,
    input wire logic MEM_VALID_IN,
    input wire logic [7:0] MEM_DATA_IN,
    output logic DONE_OUT,
    output logic FOUND_OUT,
    output logic LEGACY_OUT,
    output logic [15:0] DESC_ADDR_OUT,
    output logic [15:0] DESC_LEN_OUT,
    output walker_pkg::tag_class_t TAG_CLASS_OUT,
    output logic [15:0] TABLE_BYTES_OUT,
    output logic [15:0] STORED_CRC_OUT,
    output logic ENTRY_VALID_OUT,
    output walker_pkg::entry_t ENTRY_OUT
);
    // ==================================================================
    // helpers
    function automatic walker_pkg::tag_class_t classify(input logic [7:0] t);
        if (t == walker_pkg::LEGACY_DESCRIPTOR_TAG) begin
            return walker_pkg::CLS_LEGACY;
        end else if (t == walker_pkg::PERIPHERAL_DISCOVERY_TAG) begin
            return walker_pkg::CLS_DISCOVERY;
        end else if (t == walker_pkg::BLANK_TAG) begin
            return walker_pkg::CLS_BLANK;
        end else if (t == walker_pkg::TAG_EXTENDER_CODE) begin
            return walker_pkg::CLS_EXTENDER;
        end else if (t == walker_pkg::CONVERTER12_CALIBRATION_TAG) begin
            return walker_pkg::CLS_CAL12;
        end else if (t == walker_pkg::REFERENCE_CALIBRATION_TAG) begin
            return walker_pkg::CLS_REF;
        end else if (t == walker_pkg::CONVERTER10_CALIBRATION_TAG) begin
            return walker_pkg::CLS_CAL10;
        end else if (t == walker_pkg::SIGMA_DELTA_CALIBRATION_TAG) begin
            return walker_pkg::CLS_SIGMA;
        end else begin
            return walker_pkg::CLS_RESERVED;
        end
    endfunction : classify

    function automatic walker_pkg::id_class_t id_kind(input logic [7:0] p);
        if (p == walker_pkg::ID_NONE) begin
            return walker_pkg::ID_IS_NONE;
        end else if (p == walker_pkg::ID_SPECIAL) begin
            return walker_pkg::ID_IS_SPECIAL;
        end else if (p == walker_pkg::ID_UNDEFINED) begin
            return walker_pkg::ID_IS_UNDEFINED;
        end else begin
            return walker_pkg::ID_IS_MODULE;
        end
    endfunction : id_kind

    typedef enum {
        S_IDLE, S_FAMILY, S_INFO, S_CRC_LO, S_CRC_HI, S_TAG, S_LEN, S_EXT,
        S_LEN_LO, S_LEN_HI, S_CHECK, S_PD_HI, S_PD_LO, S_PD_COUNT, S_PD_IRQ,
        S_FINISH
    } state_t;

    state_t state_r, state_nxt;
    logic pend_r, pend_nxt, rd_r, rd_nxt;
    logic [15:0] addr_r, addr_nxt, end_r, end_nxt;
    logic [15:0] len_r, len_nxt, off_r, off_nxt, vec_r, vec_nxt;
    logic [15:0] crc_r, crc_nxt, tbytes_r, tbytes_nxt;
    logic [15:0] daddr_r, daddr_nxt, dlen_r, dlen_nxt;
    logic [7:0] tag_r, tag_nxt, ext_r, ext_nxt, hi_r, hi_nxt;
    logic [7:0] req_r, req_nxt, reqx_r, reqx_nxt, cnt_r, cnt_nxt;
    logic [19:0] paddr_r, paddr_nxt;
    logic phase_r, phase_nxt, done_r, done_nxt, found_r, found_nxt;
    logic legacy_r, legacy_nxt, ev_r, ev_nxt, busy_r, busy_nxt;
    walker_pkg::tag_class_t cls_r, cls_nxt;
    walker_pkg::entry_t ent_r, ent_nxt;
    logic got;
    logic [15:0] word, next_ptr, hdr;
    logic [19:0] punit;

    // ==================================================================
    // next-state logic
    always_comb begin
        state_nxt = state_r;
        pend_nxt = pend_r;
        rd_nxt = 1'b0;
        addr_nxt = addr_r;
        end_nxt = end_r;
        len_nxt = len_r;
        off_nxt = off_r;
        vec_nxt = vec_r;
        crc_nxt = crc_r;
        tbytes_nxt = tbytes_r;
        daddr_nxt = daddr_r;
        dlen_nxt = dlen_r;
        tag_nxt = tag_r;
        ext_nxt = ext_r;
        hi_nxt = hi_r;
        req_nxt = req_r;
        reqx_nxt = reqx_r;
        cnt_nxt = cnt_r;
        paddr_nxt = paddr_r;
        phase_nxt = phase_r;
        done_nxt = 1'b0;
        found_nxt = found_r;
        legacy_nxt = legacy_r;
        ev_nxt = 1'b0;
        cls_nxt = cls_r;
        ent_nxt = ent_r;
        word = {hi_r, MEM_DATA_IN};
        hdr = (tag_r == walker_pkg::TAG_EXTENDER_CODE) ?
            walker_pkg::EXT_HDR : walker_pkg::SHORT_HDR;
        next_ptr = addr_r + len_r + hdr;
        punit = word[7] ? walker_pkg::PER_LARGE_UNIT :
            walker_pkg::PER_SMALL_UNIT;
        // one read in flight
        got = 1'b0;
        if (state_r != S_IDLE && state_r != S_CHECK &&
                state_r != S_FINISH) begin
            if (!pend_r) begin
                rd_nxt = 1'b1;
                pend_nxt = 1'b1;
            end else if (MEM_VALID_IN) begin
                got = 1'b1;
                pend_nxt = 1'b0;
            end
        end
        case (state_r)
            S_IDLE: begin
                if (REQ_VALID_IN) begin
                    req_nxt = REQ_TAG_IN;
                    reqx_nxt = REQ_EXT_TAG_IN;
                    found_nxt = 1'b0;
                    legacy_nxt = 1'b0;
                    addr_nxt = walker_pkg::FAMILY_ADDR;
                    state_nxt = S_FAMILY;
                end
            end
            S_FAMILY: begin
                if (got && MEM_DATA_IN == walker_pkg::HIER_MARK) begin
                    addr_nxt = walker_pkg::INFO_LEN_ADDR;
                    state_nxt = S_INFO;
                end else if (got) begin
                    legacy_nxt = 1'b1;
                    daddr_nxt = walker_pkg::LEGACY_ADDR;
                    state_nxt = S_FINISH;
                end
            end
            S_INFO: begin
                if (got) begin
                    // table bytes
                    tbytes_nxt = 16'(walker_pkg::WORD_BYTES << MEM_DATA_IN);
                    end_nxt = 16'(walker_pkg::INFO_BASE +
                        (walker_pkg::WORD_BYTES << MEM_DATA_IN));
                    addr_nxt = walker_pkg::CRC_LO_ADDR;
                    state_nxt = S_CRC_LO;
                end
            end
            S_CRC_LO: begin
                if (got) begin
                    crc_nxt[7:0] = MEM_DATA_IN;
                    addr_nxt = walker_pkg::CRC_HI_ADDR;
                    state_nxt = S_CRC_HI;
                end
            end
            S_CRC_HI: begin
                if (got) begin
                    crc_nxt[15:8] = MEM_DATA_IN;
                    addr_nxt = walker_pkg::CHAIN_START_ADDRESS;
                    state_nxt = S_TAG;
                end
            end
            S_TAG: begin
                if (got) begin
                    tag_nxt = MEM_DATA_IN;
                    addr_nxt = addr_r + 16'h0001;
                    if (MEM_DATA_IN == walker_pkg::CHAIN_TERMINATOR_TAG &&
                            req_r != walker_pkg::CHAIN_TERMINATOR_TAG) begin
                        state_nxt = S_FINISH;
                    end else if (MEM_DATA_IN ==
                            walker_pkg::TAG_EXTENDER_CODE) begin
                        state_nxt = S_EXT;
                    end else begin
                        state_nxt = S_LEN;
                    end
                end
            end
            S_LEN: begin
                if (got) begin
                    len_nxt = {8'h00, MEM_DATA_IN};
                    addr_nxt = addr_r - 16'h0001;
                    state_nxt = S_CHECK;
                end
            end
            S_EXT: begin
                if (got) begin
                    ext_nxt = MEM_DATA_IN;
                    addr_nxt = addr_r + 16'h0001;
                    state_nxt = S_LEN_LO;
                end
            end
            S_LEN_LO: begin
                if (got) begin
                    len_nxt[7:0] = MEM_DATA_IN;
                    addr_nxt = addr_r + 16'h0001;
                    state_nxt = S_LEN_HI;
                end
            end
            S_LEN_HI: begin
                if (got) begin
                    len_nxt[15:8] = MEM_DATA_IN;
                    addr_nxt = addr_r - 16'h0003;
                    state_nxt = S_CHECK;
                end
            end
            S_CHECK: begin
                if (tag_r == req_r && (tag_r != walker_pkg::TAG_EXTENDER_CODE
                        || ext_r == reqx_r)) begin
                    found_nxt = 1'b1;
                    daddr_nxt = addr_r;
                    dlen_nxt = len_r;
                    cls_nxt = classify(tag_r);
                    state_nxt = S_FINISH;
                    if (tag_r == walker_pkg::PERIPHERAL_DISCOVERY_TAG) begin
                        addr_nxt = addr_r + hdr;
                        off_nxt = 16'h0000;
                        phase_nxt = 1'b0;
                        paddr_nxt = 20'h0_0000;
                        vec_nxt = walker_pkg::VEC_FIRST;
                        state_nxt = S_PD_HI;
                    end
                end else if (next_ptr >= end_r || next_ptr < addr_r) begin
                    state_nxt = S_FINISH;
                end else begin
                    addr_nxt = next_ptr;
                    state_nxt = S_TAG;
                end
            end
            S_PD_HI: begin
                if (off_r >= dlen_r) begin
                    state_nxt = S_FINISH;
                end else if (got) begin
                    addr_nxt = addr_r + 16'h0001;
                    off_nxt = off_r + 16'h0001;
                    hi_nxt = MEM_DATA_IN;
                    if (!phase_r && MEM_DATA_IN == walker_pkg::DELIMITER) begin
                        state_nxt = S_PD_COUNT;
                    end else begin
                        state_nxt = S_PD_LO;
                    end
                end
            end
            S_PD_LO: begin
                if (got) begin
                    addr_nxt = addr_r + 16'h0001;
                    off_nxt = off_r + 16'h0001;
                    ev_nxt = 1'b1;
                    ent_nxt.more = word[8];
                    ent_nxt.mem_type = word[15:13];
                    ent_nxt.size_code = word[12:9];
                    ent_nxt.size_bytes = (word[12:9] == 4'h0 ||
                        word[12:9] >= walker_pkg::SIZE_APPENDED) ? 20'h0_0000
                        : 20'(walker_pkg::SIZE_BASE << (word[12:9] - 4'h1));
                    ent_nxt.peripheral_identifier = word[15:8];
                    ent_nxt.id_class = id_kind(word[15:8]);
                    state_nxt = S_PD_HI;
                    if (!phase_r) begin
                        ent_nxt.kind = walker_pkg::ENT_MEMORY;
                        ent_nxt.address = {17'h0_0000, word[6:0]} *
                            (word[7] ? walker_pkg::MEM_LARGE_UNIT :
                            walker_pkg::MEM_SMALL_UNIT);
                    end else begin
                        ent_nxt.kind = walker_pkg::ENT_PERIPHERAL;
                        paddr_nxt = paddr_r + 20'({13'h0000, word[6:0]} *
                            punit);
                        ent_nxt.address = {4'h0, paddr_nxt};
                        cnt_nxt = cnt_r - 8'h01;
                        if (cnt_r == 8'h01) begin
                            state_nxt = S_PD_IRQ;
                        end
                    end
                end
            end
            S_PD_COUNT: begin
                if (got) begin
                    addr_nxt = addr_r + 16'h0001;
                    off_nxt = off_r + 16'h0001;
                    cnt_nxt = MEM_DATA_IN;
                    phase_nxt = 1'b1;
                    state_nxt = (MEM_DATA_IN == 8'h00) ? S_PD_IRQ : S_PD_HI;
                end
            end
            S_PD_IRQ: begin
                if (off_r >= dlen_r) begin
                    state_nxt = S_FINISH;
                end else if (got && MEM_DATA_IN == walker_pkg::DELIMITER) begin
                    state_nxt = S_FINISH;
                end else if (got) begin
                    addr_nxt = addr_r + 16'h0001;
                    off_nxt = off_r + 16'h0001;
                    ev_nxt = 1'b1;
                    ent_nxt.kind = walker_pkg::ENT_INTERRUPT;
                    ent_nxt.peripheral_identifier = MEM_DATA_IN;
                    ent_nxt.id_class = id_kind(MEM_DATA_IN);
                    ent_nxt.address = {8'h00, vec_r};
                    vec_nxt = vec_r - walker_pkg::VEC_STEP;
                end
            end
            S_FINISH: begin
                done_nxt = 1'b1;
                state_nxt = S_IDLE;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != S_IDLE);
    end

    // ==================================================================
    // state registers
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_r <= S_IDLE;
            pend_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= 16'h0000;
            end_r <= 16'h0000;
            len_r <= 16'h0000;
            off_r <= 16'h0000;
            vec_r <= 16'h0000;
            crc_r <= 16'h0000;
            tbytes_r <= 16'h0000;
            daddr_r <= 16'h0000;
            dlen_r <= 16'h0000;
            tag_r <= 8'h00;
            ext_r <= 8'h00;
            hi_r <= 8'h00;
            req_r <= 8'h00;
            reqx_r <= 8'h00;
            cnt_r <= 8'h00;
            paddr_r <= 20'h0_0000;
            phase_r <= 1'b0;
            done_r <= 1'b0;
            found_r <= 1'b0;
            legacy_r <= 1'b0;
            ev_r <= 1'b0;
            busy_r <= 1'b0;
            cls_r <= walker_pkg::CLS_RESERVED;
            ent_r <= '0;
        end else begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            rd_r <= rd_nxt;
            addr_r <= addr_nxt;
            end_r <= end_nxt;
            len_r <= len_nxt;
            off_r <= off_nxt;
            vec_r <= vec_nxt;
            crc_r <= crc_nxt;
            tbytes_r <= tbytes_nxt;
            daddr_r <= daddr_nxt;
            dlen_r <= dlen_nxt;
            tag_r <= tag_nxt;
            ext_r <= ext_nxt;
            hi_r <= hi_nxt;
            req_r <= req_nxt;
            reqx_r <= reqx_nxt;
            cnt_r <= cnt_nxt;
            paddr_r <= paddr_nxt;
            phase_r <= phase_nxt;
            done_r <= done_nxt;
            found_r <= found_nxt;
            legacy_r <= legacy_nxt;
            ev_r <= ev_nxt;
            busy_r <= busy_nxt;
            cls_r <= cls_nxt;
            ent_r <= ent_nxt;
        end
    end

    // outputs straight from flip-flops
    assign BUSY_OUT = busy_r;
    assign MEM_RD_OUT = rd_r;
    assign MEM_ADDR_OUT = addr_r;
    assign DONE_OUT = done_r;
    assign FOUND_OUT = found_r;
    assign LEGACY_OUT = legacy_r;
    assign DESC_ADDR_OUT = daddr_r;
    assign DESC_LEN_OUT = dlen_r;
    assign TAG_CLASS_OUT = cls_r;
    assign TABLE_BYTES_OUT = tbytes_r;
    assign STORED_CRC_OUT = crc_r;
    assign ENTRY_VALID_OUT = ev_r;
    assign ENTRY_OUT = ent_r;
endmodule : descriptor_walker
`default_nettype wire

// [shared/walker_pkg.sv]
`default_nettype none
package walker_pkg;
    // ==================================================================
    // table locations
    localparam logic [15:0] FAMILY_ADDR = 16'h0FF0;
    localparam logic [15:0] LEGACY_ADDR = 16'h0FF0;
    localparam logic [15:0] INFO_LEN_ADDR = 16'h1A00;
    localparam logic [15:0] INFO_BASE = 16'h1A00;
    localparam logic [15:0] CRC_LO_ADDR = 16'h1A02;
    localparam logic [15:0] CRC_HI_ADDR = 16'h1A03;
    localparam logic [15:0] CRC_FIRST_ADDR = 16'h1A04;
    localparam logic [15:0] CRC_LAST_ADDR = 16'h1AFF;
    localparam logic [15:0] CHAIN_START_ADDRESS = 16'h1A08;
    localparam logic [15:0] WORD_BYTES = 16'h0004;
    // ==================================================================
    // tag codes
    localparam logic [7:0] HIER_MARK = 8'h80;
    localparam logic [7:0] LEGACY_DESCRIPTOR_TAG = 8'h01;
    localparam logic [7:0] PERIPHERAL_DISCOVERY_TAG = 8'h02;
    localparam logic [7:0] BLANK_TAG = 8'h05;
    localparam logic [7:0] CONVERTER12_CALIBRATION_TAG = 8'h11;
    localparam logic [7:0] REFERENCE_CALIBRATION_TAG = 8'h12;
    localparam logic [7:0] CONVERTER10_CALIBRATION_TAG = 8'h13;
    localparam logic [7:0] SIGMA_DELTA_CALIBRATION_TAG = 8'h1D;
    localparam logic [7:0] TAG_EXTENDER_CODE = 8'hFE;
    localparam logic [7:0] CHAIN_TERMINATOR_TAG = 8'hFF;
    localparam logic [15:0] SHORT_HDR = 16'h0002;
    localparam logic [15:0] EXT_HDR = 16'h0004;
    // ==================================================================
    // discovery fields
    localparam logic [7:0] DELIMITER = 8'h00;
    localparam logic [23:0] MEM_SMALL_UNIT = 24'h00_0200;
    localparam logic [23:0] MEM_LARGE_UNIT = 24'h01_0000;
    localparam logic [19:0] PER_SMALL_UNIT = 20'h0_0010;
    localparam logic [19:0] PER_LARGE_UNIT = 20'h0_0800;
    localparam logic [19:0] SIZE_BASE = 20'h0_0080;
    localparam logic [3:0] SIZE_APPENDED = 4'hE;
    localparam logic [7:0] ID_NONE = 8'h00;
    localparam logic [7:0] ID_SPECIAL = 8'hFE;
    localparam logic [7:0] ID_UNDEFINED = 8'hFF;
    localparam logic [15:0] VEC_FIRST = 16'hFFF8;
    localparam logic [15:0] VEC_STEP = 16'h0002;

    typedef enum logic [3:0] {
        CLS_LEGACY, CLS_DISCOVERY, CLS_BLANK, CLS_EXTENDER, CLS_CAL12,
        CLS_REF, CLS_CAL10, CLS_SIGMA, CLS_RESERVED
    } tag_class_t;

    typedef enum logic [1:0] {
        ENT_MEMORY, ENT_PERIPHERAL, ENT_INTERRUPT
    } entry_kind_t;

    typedef enum logic [1:0] {
        ID_IS_MODULE, ID_IS_NONE, ID_IS_SPECIAL, ID_IS_UNDEFINED
    } id_class_t;

    typedef struct packed {
        entry_kind_t kind;
        logic [2:0] mem_type;
        logic [3:0] size_code;
        logic [19:0] size_bytes;
        logic more;
        logic [23:0] address;
        logic [7:0] peripheral_identifier;
        id_class_t id_class;
    } entry_t;
endpackage : walker_pkg
`default_nettype wire
